// ---- logic/ptsq_pkg.sv ----
// Package: offsets, field positions, reset values and timing constants
package ptsq_pkg;
	// Core clock and timebase derivation
	localparam int unsigned CORE_CLK_HZ = 250_000_000;
	localparam int unsigned TB_FAST_HZ = 5_000_000;
	localparam int unsigned TB_FAST_DIV = CORE_CLK_HZ / TB_FAST_HZ;
	localparam int unsigned TB_FIRST_STEP = 5;
	localparam int unsigned TB_DECADE_STEP = 10;
	localparam int unsigned TB_COUNT = 6;
	// Register word offsets
	localparam logic [7:0] OFS_CMD1 = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h01;
	localparam logic [7:0] OFS_MEM_CLEAR = 8'h02;
	localparam logic [7:0] OFS_MEM_ENTRY = 8'h03;
	localparam logic [7:0] OFS_MEM_FIRST = 8'h04;
	localparam logic [7:0] OFS_SW_START = 8'h05;
	localparam logic [7:0] OFS_SI_MODE = 8'h06;
	localparam logic [7:0] OFS_SI_RELOAD = 8'h07;
	localparam logic [7:0] OFS_SC_MODE = 8'h08;
	localparam logic [7:0] OFS_SC_RELOAD = 8'h09;
	localparam logic [7:0] OFS_CNT_LOW = 8'h0A;
	localparam logic [7:0] OFS_CNT_HIGH = 8'h0B;
	// Command register 1 field positions
	localparam int unsigned CMD_DAQ_EN = 0;
	localparam int unsigned CMD_SCAN_EN = 1;
	localparam int unsigned CMD_SCAN_IVL_EN = 2;
	localparam int unsigned CMD_WIDE_COUNT = 3;
	localparam int unsigned CMD_PER_ENTRY_DIV = 4;
	localparam int unsigned CMD_WIDTH = 5;
	// Scan memory entry: channel/gain in low byte, end flag above it
	localparam int unsigned ENTRY_CG_W = 8;
	localparam int unsigned ENTRY_END_BIT = 8;
	// Counter mode words
	localparam logic [15:0] MODE_TB_5M = 16'h8225;
	localparam logic [15:0] MODE_TB_1M = 16'h8B25;
	localparam logic [15:0] MODE_TB_100K = 16'h8C25;
	localparam logic [15:0] MODE_TB_10K = 16'h8D25;
	localparam logic [15:0] MODE_TB_1K = 16'h8E25;
	localparam logic [15:0] MODE_TB_100 = 16'h8F25;
	localparam logic [15:0] MODE_SRC_FIVE = 16'h8525;
	// Reset values
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [16:0] CNT_FULL = 17'h10000;
endpackage

// ---- logic/ptsq_interval_counter.sv ----
// Reloading interval counter: one pulse every N timebase ticks
`timescale 1ns/100ps
`default_nettype none
module ptsq_interval_counter (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Control
	input wire logic i_start,
	input wire logic i_run,
	input wire logic i_tick,
	input wire logic [15:0] i_reload,
	// Terminal pulse
	output logic o_pulse
);
	logic [16:0] cnt_r;
	logic [16:0] reload_eff;

	// A reload of zero stands for the full 65,536-count interval
	assign reload_eff = (i_reload == 16'h0000) ? ptsq_pkg::CNT_FULL :
		{1'b0, i_reload};

	// Count down, reload and pulse at the end of each interval
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_r <= ptsq_pkg::CNT_FULL;
			o_pulse <= 1'b0;
		end else begin
			o_pulse <= 1'b0;
			if (i_start) begin
				cnt_r <= reload_eff;
			end else if (i_run && i_tick) begin
				if (cnt_r <= 17'h00001) begin
					cnt_r <= reload_eff;
					o_pulse <= 1'b1;
				end else begin
					cnt_r <= cnt_r - 17'h00001;
				end
			end
		end
	end
endmodule // ptsq_interval_counter
`default_nettype wire

// ---- logic/ptsq_sequencer.sv ----
// Pretrigger scanned acquisition sequencer with register port
// What this block does
// - Sample-interval counter gives one low conversion pulse every N timebase counts.
// - Mode word picks 5 MHz down to 100 Hz timebase or source five edges.
// - Armed interval counter stays quiet until a trigger, then pulses each interval.
// - Sample counter tallies conversions and stops the interval counter at its end.
// - Wide-count select: clear for counter four alone, set for chaining.
// - In 16-bit mode acquisition stops when counter four reaches zero.
// - Chained: five steps when four hits zero; end needs both zero and last entry.
// - Counting starts only at the second trigger; earlier samples are pretrigger.
// - Scan-interval counter pulses every N timebase counts to space scan sequences.
// - After a sequence ends, the next waits for the scan-interval terminal count.
// - Scan memory advances per conversion, or on low first-counter pulse if divided.
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module ptsq_sequencer #(
	parameter int unsigned DEPTH = 16,
	parameter int unsigned AW = 4
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// Trigger and timebase pins
	input wire logic i_external_trigger_n,
	input wire logic i_external_source_five,
	input wire logic i_first_counter_out_n,
	// Converter side
	output logic o_convert_n,
	output logic [7:0] o_channel_gain,
	output logic o_sequence_end_flag,
	// Acquisition state
	output logic o_acq_running,
	output logic o_counting,
	output logic o_done
);
	localparam int unsigned TBW = 8;

	logic [ptsq_pkg::CMD_WIDTH-1:0] cmd_r;
	logic [15:0] si_mode_r, si_reload_r, sc_mode_r, sc_reload_r;
	logic [15:0] cnt_low_r, cnt_high_r;
	logic [ptsq_pkg::ENTRY_END_BIT:0] mem_r [DEPTH];
	logic [AW:0] wcnt_r;
	logic [AW-1:0] rptr_r, last_idx;
	logic [TBW-1:0] tb_div_r [ptsq_pkg::TB_COUNT];
	logic [ptsq_pkg::TB_COUNT-1:0] tb_tick_r;
	logic trig_q_r, src5_q_r, out1_q_r;
	logic running_r, counting_r, final_r, wait_scan_r;
	logic [1:0] trig_cnt_r;
	logic [16:0] c4_r;
	logic [15:0] c5_r;
	logic trig, acq_start, si_tick, sc_tick, si_pulse, sc_pulse;
	logic conv_fire, counted, at_last, advance, src5_rise, sw_start;

	// Timebase select from a mode word; unknown words give no ticks
	function automatic logic tb_sel(input logic [15:0] mode,
		input logic [ptsq_pkg::TB_COUNT-1:0] t, input logic s5);
		case (mode)
			ptsq_pkg::MODE_TB_5M: tb_sel = t[0];
			ptsq_pkg::MODE_TB_1M: tb_sel = t[1];
			ptsq_pkg::MODE_TB_100K: tb_sel = t[2];
			ptsq_pkg::MODE_TB_10K: tb_sel = t[3];
			ptsq_pkg::MODE_TB_1K: tb_sel = t[4];
			ptsq_pkg::MODE_TB_100: tb_sel = t[5];
			ptsq_pkg::MODE_SRC_FIVE: tb_sel = s5;
			default: tb_sel = 1'b0;
		endcase
	endfunction

	// Register writes; strobe registers act and store nothing
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cmd_r <= '0;
			si_mode_r <= ptsq_pkg::RST_WORD;
			si_reload_r <= ptsq_pkg::RST_WORD;
			sc_mode_r <= ptsq_pkg::RST_WORD;
			sc_reload_r <= ptsq_pkg::RST_WORD;
			cnt_low_r <= ptsq_pkg::RST_WORD;
			cnt_high_r <= ptsq_pkg::RST_WORD;
		end else if (i_wr) begin
			case (i_addr)
				ptsq_pkg::OFS_CMD1: cmd_r <= i_wdata[ptsq_pkg::CMD_WIDTH-1:0];
				ptsq_pkg::OFS_SI_MODE: si_mode_r <= i_wdata;
				ptsq_pkg::OFS_SI_RELOAD: si_reload_r <= i_wdata;
				ptsq_pkg::OFS_SC_MODE: sc_mode_r <= i_wdata;
				ptsq_pkg::OFS_SC_RELOAD: sc_reload_r <= i_wdata;
				ptsq_pkg::OFS_CNT_LOW: cnt_low_r <= i_wdata;
				ptsq_pkg::OFS_CNT_HIGH: cnt_high_r <= i_wdata;
				default: ;
			endcase
		end
	end

	// Registered read data, valid in the cycle after the strobe
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= ptsq_pkg::RST_WORD;
		end else if (i_rd) begin
			case (i_addr)
				ptsq_pkg::OFS_CMD1: o_rdata <= {11'h000, cmd_r};
				ptsq_pkg::OFS_STATUS: o_rdata <= {10'h000, wait_scan_r,
					final_r, trig_cnt_r, counting_r, running_r};
				ptsq_pkg::OFS_SI_MODE: o_rdata <= si_mode_r;
				ptsq_pkg::OFS_SI_RELOAD: o_rdata <= si_reload_r;
				ptsq_pkg::OFS_SC_MODE: o_rdata <= sc_mode_r;
				ptsq_pkg::OFS_SC_RELOAD: o_rdata <= sc_reload_r;
				ptsq_pkg::OFS_CNT_LOW: o_rdata <= c4_r[15:0];
				ptsq_pkg::OFS_CNT_HIGH: o_rdata <= c5_r;
				default: o_rdata <= ptsq_pkg::RST_WORD;
			endcase
		end else begin
			o_rdata <= ptsq_pkg::RST_WORD;
		end
	end

	// Timebase ladder: 5 MHz from the core clock, then /5 and decades
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < ptsq_pkg::TB_COUNT; i++) begin
				tb_div_r[i] <= '0;
			end
			tb_tick_r <= '0;
		end else begin
			for (int i = 0; i < ptsq_pkg::TB_COUNT; i++) begin
				if (i == 0 || tb_tick_r[i == 0 ? 0 : i - 1]) begin
					if (tb_div_r[i] == TBW'(i == 0 ? ptsq_pkg::TB_FAST_DIV - 1 :
						i == 1 ? ptsq_pkg::TB_FIRST_STEP - 1 :
						ptsq_pkg::TB_DECADE_STEP - 1)) begin
						tb_div_r[i] <= '0;
						tb_tick_r[i] <= 1'b1;
					end else begin
						tb_div_r[i] <= tb_div_r[i] + TBW'(1);
						tb_tick_r[i] <= 1'b0;
					end
				end else begin
					tb_tick_r[i] <= 1'b0;
				end
			end
		end
	end

	// Previous pin samples for edge detection
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			trig_q_r <= 1'b1;
			src5_q_r <= 1'b0;
			out1_q_r <= 1'b1;
		end else begin
			trig_q_r <= i_external_trigger_n;
			src5_q_r <= i_external_source_five;
			out1_q_r <= i_first_counter_out_n;
		end
	end

	assign src5_rise = i_external_source_five & ~src5_q_r;
	assign si_tick = tb_sel(si_mode_r, tb_tick_r, src5_rise);
	assign sc_tick = tb_sel(sc_mode_r, tb_tick_r, src5_rise);
	assign sw_start = i_wr && (i_addr == ptsq_pkg::OFS_SW_START);
	// A held-low trigger pin counts once, at its falling edge
	assign trig = cmd_r[ptsq_pkg::CMD_DAQ_EN] &&
		((trig_q_r && !i_external_trigger_n) || sw_start);
	assign acq_start = trig && !running_r;
	assign conv_fire = si_pulse && running_r && !wait_scan_r;
	assign counted = conv_fire && counting_r;
	assign last_idx = (wcnt_r == '0) ? '0 : AW'(wcnt_r - (AW+1)'(1));
	assign at_last = (rptr_r == last_idx);

	// Sample-interval counter runs only between first trigger and the end
	ptsq_interval_counter u_sample_ivl (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_start(acq_start),
		.i_run(running_r),
		.i_tick(si_tick),
		.i_reload(si_reload_r),
		.o_pulse(si_pulse)
	);

	// Scan-interval counter starts with the first scan sequence
	ptsq_interval_counter u_scan_ivl (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_start(acq_start),
		.i_run(running_r),
		.i_tick(sc_tick),
		.i_reload(sc_reload_r),
		.o_pulse(sc_pulse)
	);

	// Trigger sequencing and sample counting
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			running_r <= 1'b0;
			counting_r <= 1'b0;
			final_r <= 1'b0;
			trig_cnt_r <= 2'h0;
			c4_r <= ptsq_pkg::CNT_FULL;
			c5_r <= ptsq_pkg::RST_WORD;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (acq_start) begin
				running_r <= 1'b1;
				trig_cnt_r <= 2'h1;
				c4_r <= (cnt_low_r == 16'h0000 &&
					!cmd_r[ptsq_pkg::CMD_WIDE_COUNT]) ?
					ptsq_pkg::CNT_FULL : {1'b0, cnt_low_r};
				c5_r <= cnt_high_r;
			end else if (trig && !counting_r) begin
				counting_r <= 1'b1;
				trig_cnt_r <= 2'h2;
			end else if (counted) begin
				if (!cmd_r[ptsq_pkg::CMD_WIDE_COUNT]) begin
					c4_r <= c4_r - 17'h00001;
					if (c4_r == 17'h00001) begin
						running_r <= 1'b0;
						counting_r <= 1'b0;
						trig_cnt_r <= 2'h0;
						o_done <= 1'b1;
					end
				end else if (final_r && at_last) begin
					running_r <= 1'b0;
					counting_r <= 1'b0;
					final_r <= 1'b0;
					trig_cnt_r <= 2'h0;
					o_done <= 1'b1;
				end else if (!final_r) begin
					// Counter four wraps through zero to FFFF
					c4_r <= {1'b0, c4_r[15:0] - 16'h0001};
					if (c4_r[15:0] == 16'h0001) begin
						c5_r <= c5_r - 16'h0001;
						if (c5_r <= 16'h0001) begin
							final_r <= 1'b1;
						end
					end
				end
			end
		end
	end

	// Hold off after a sequence end until the scan interval expires
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wait_scan_r <= 1'b0;
		end else if (!running_r) begin
			wait_scan_r <= 1'b0;
		end else if (conv_fire && cmd_r[ptsq_pkg::CMD_SCAN_IVL_EN] &&
			(mem_r[rptr_r][ptsq_pkg::ENTRY_END_BIT] || at_last)) begin
			wait_scan_r <= 1'b1;
		end else if (sc_pulse) begin
			wait_scan_r <= 1'b0;
		end
	end

	// Entry advance source depends on the per-entry divide option
	assign advance = cmd_r[ptsq_pkg::CMD_SCAN_EN] &&
		(cmd_r[ptsq_pkg::CMD_PER_ENTRY_DIV] ?
		(out1_q_r && !i_first_counter_out_n) : conv_fire);

	// Scan memory: clear, sequential load, first-entry select, stepping
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wcnt_r <= '0;
			rptr_r <= '0;
		end else if (i_wr && i_addr == ptsq_pkg::OFS_MEM_CLEAR) begin
			wcnt_r <= '0;
			rptr_r <= '0;
		end else if (i_wr && i_addr == ptsq_pkg::OFS_MEM_ENTRY) begin
			// Entries past the memory depth are dropped
			if (wcnt_r < (AW+1)'(DEPTH)) begin
				wcnt_r <= wcnt_r + (AW+1)'(1);
			end
		end else if (i_wr && i_addr == ptsq_pkg::OFS_MEM_FIRST) begin
			rptr_r <= '0;
		end else if (o_done) begin
			rptr_r <= '0;
		end else if (advance) begin
			rptr_r <= at_last ? '0 : rptr_r + AW'(1);
		end
	end

	// Entry storage keeps the end flag beside the channel/gain code
	always_ff @(posedge i_core_clk) begin
		if (i_wr && i_addr == ptsq_pkg::OFS_MEM_ENTRY &&
			wcnt_r < (AW+1)'(DEPTH)) begin
			mem_r[AW'(wcnt_r)] <= i_wdata[ptsq_pkg::ENTRY_END_BIT:0];
		end
	end

	// Converter outputs from flip-flops
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_convert_n <= 1'b1;
			o_channel_gain <= 8'h00;
			o_sequence_end_flag <= 1'b0;
		end else begin
			o_convert_n <= !conv_fire;
			o_channel_gain <= (wcnt_r == '0) ? 8'h00 :
				mem_r[rptr_r][ptsq_pkg::ENTRY_CG_W-1:0];
			o_sequence_end_flag <= (wcnt_r == '0) ? 1'b0 :
				mem_r[rptr_r][ptsq_pkg::ENTRY_END_BIT];
		end
	end

	assign o_acq_running = running_r;
	assign o_counting = counting_r;
endmodule // ptsq_sequencer
`default_nettype wire

// ---- tb/ptsq_sequencer_sva.sv ----
// Checker: port-level properties of the acquisition sequencer
`timescale 1ns/100ps
`default_nettype none
module ptsq_sequencer_sva (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic i_external_trigger_n,
	input wire logic o_convert_n,
	input wire logic o_acq_running,
	input wire logic o_counting,
	input wire logic o_done
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// A tick needs a rising edge, so two ticks span at least two cycles; pulses here must be four apart
	property p_conv_width;
		$fell(o_convert_n) |=> o_convert_n[*3];
	endproperty
	a_conv_width: assert property (p_conv_width)
		else $error("conversion pulses too close");
	property p_conv_run;
		!o_convert_n |-> $past(o_acq_running);
	endproperty
	a_conv_run: assert property (p_conv_run)
		else $error("conversion outside acquisition");
	property p_count_run;
		o_counting |-> o_acq_running;
	endproperty
	a_count_run: assert property (p_count_run)
		else $error("counting without acquisition");
	// The last counted conversion and the end share one cycle
	property p_done;
		o_done |-> !o_convert_n && !o_acq_running && $past(o_counting);
	endproperty
	a_done: assert property (p_done)
		else $error("end without a counted conversion");
	property p_count_start;
		$rose(o_counting) |-> $past(o_acq_running);
	endproperty
	a_count_start: assert property (p_count_start)
		else $error("counting began before first trigger");
	property p_run_cause;
		$rose(o_acq_running) |-> $past(i_wr && i_addr == ptsq_pkg::OFS_SW_START)
			|| ($past(i_external_trigger_n, 2) && !$past(i_external_trigger_n));
	endproperty
	a_run_cause: assert property (p_run_cause)
		else $error("acquisition began with no trigger");
	property p_status;
		$past(i_rd && i_addr == ptsq_pkg::OFS_STATUS)
			|-> o_rdata[1:0] == {$past(o_counting), $past(o_acq_running)};
	endproperty
	a_status: assert property (p_status)
		else $error("status bits disagree with outputs");
	property p_rdata_idle;
		!$past(i_rd) |-> o_rdata == 16'h0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside its cycle");
	c_done: cover property (o_done);
	c_count: cover property ($rose(o_counting));
	c_conv: cover property ($fell(o_convert_n));
endmodule // ptsq_sequencer_sva
bind ptsq_sequencer ptsq_sequencer_sva u_sva (.*);
`default_nettype wire

// ---- tb/ptsq_far_end.sv ----
// Far-side model: trigger source, external timebase, first counter
`timescale 1ns/100ps
`default_nettype none
module ptsq_far_end (
	// Clock, reset and bench controls
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_fire,
	input wire logic i_src_run,
	input wire logic i_convert_n,
	// Pins into the sequencer
	output logic o_trig_n,
	output logic o_src_five,
	output logic o_first_out_n
);
	logic [1:0] low_r;
	logic [1:0] div_r;
	logic half_r;
	// Trigger pin rests high (pulled up) and falls three cycles per fire
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			low_r <= 2'h0;
		end else if (i_fire) begin
			low_r <= 2'h3;
		end else if (low_r != 2'h0) begin
			low_r <= low_r - 2'h1;
		end
	end
	assign o_trig_n = (low_r == 2'h0);
	// Source five: six-cycle period, stands low when stopped
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			div_r <= 2'h0;
			o_src_five <= 1'b0;
		end else if (!i_src_run) begin
			div_r <= 2'h0;
			o_src_five <= 1'b0;
		end else if (div_r == 2'h2) begin
			div_r <= 2'h0;
			o_src_five <= ~o_src_five;
		end else begin
			div_r <= div_r + 2'h1;
		end
	end
	// First counter output pulses low after every second conversion
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			half_r <= 1'b0;
			o_first_out_n <= 1'b1;
		end else begin
			o_first_out_n <= !(!i_convert_n && half_r);
			half_r <= half_r ^ !i_convert_n;
		end
	end
endmodule // ptsq_far_end
`default_nettype wire

// ---- tb/pretrigger_scan_acquisition_sequencer_bench.sv ----
// Bench: register-level acquisition runs against the sequencer
`timescale 1ns/100ps
`default_nettype none
module pretrigger_scan_acquisition_sequencer_bench;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [15:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic fire = 1'b0;
	logic src_run = 1'b0;
	logic [15:0] o_rdata;
	logic [7:0] o_channel_gain;
	logic i_external_trigger_n, i_external_source_five, i_first_counter_out_n;
	logic o_convert_n, o_sequence_end_flag, o_acq_running, o_counting, o_done;
	int n_mismatch = 0;
	int checks_done = 0;
	int n_counted = 0;
	int cyc = 0;
	logic [7:0] cg_q[$];
	logic end_q[$];
	int t_q[$];
	always #2 i_core_clk = ~i_core_clk;
	ptsq_sequencer u_dut (.*);
	ptsq_far_end u_far (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_fire(fire),
		.i_src_run(src_run), .i_convert_n(o_convert_n),
		.o_trig_n(i_external_trigger_n), .o_src_five(i_external_source_five),
		.o_first_out_n(i_first_counter_out_n));
	// Conversion log sampled mid-cycle, clear of the launching edge
	always @(negedge i_core_clk) begin
		cyc++;
		if (o_convert_n === 1'b0) begin
			cg_q.push_back(o_channel_gain);
			end_q.push_back(o_sequence_end_flag);
			t_q.push_back(cyc);
			if (o_counting === 1'b1 || o_done === 1'b1)
				n_counted++;
		end
	end
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e, input string what);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1;
		chk(what, e, o_rdata);
	endtask
	task automatic fire_pin();
		@(posedge i_core_clk);
		fire <= 1'b1;
		@(posedge i_core_clk);
		fire <= 1'b0;
	endtask
	// Bounded waits so a stuck design cannot hang the run
	task automatic wait_done(input int lim);
		int k;
		k = 0;
		while (o_done !== 1'b1 && k < lim) begin
			@(negedge i_core_clk);
			k++;
		end
		chk("done", 16'h0001, {15'h0000, o_done});
		// The log pushes at this same negedge, so let it settle first
		@(posedge i_core_clk);
	endtask
	task automatic wait_conv(input int n);
		int k;
		k = 0;
		while (cg_q.size() < n && k < 500) begin
			@(negedge i_core_clk);
			k++;
		end
	endtask
	task automatic end_of_test();
		$display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge i_core_clk);
		i_rst <= 1'b0;
		#1;
		chk("reset outputs", 16'h1000, {o_convert_n, o_channel_gain,
			o_sequence_end_flag, o_acq_running, o_counting, o_done});
		rd(8'h3F, 16'h0000, "unmapped");
		wr(ptsq_pkg::OFS_SW_START, 16'h0000);
		rd(ptsq_pkg::OFS_STATUS, 16'h0000, "disabled start");
		// Three entries, the last closes the sequence; two starts back to back
		wr(ptsq_pkg::OFS_MEM_CLEAR, 16'h0000);
		for (int i = 1; i < 4; i++)
			wr(ptsq_pkg::OFS_MEM_ENTRY, {7'h00, i == 3, 8'(8'h11 * i)});
		wr(ptsq_pkg::OFS_MEM_FIRST, 16'h0000);
		wr(ptsq_pkg::OFS_SI_MODE, ptsq_pkg::MODE_TB_5M);
		wr(ptsq_pkg::OFS_SI_RELOAD, 16'h0002);
		wr(ptsq_pkg::OFS_CNT_LOW, 16'h0003);
		wr(ptsq_pkg::OFS_CMD1, 16'h0003);
		wr(ptsq_pkg::OFS_SW_START, 16'h0000);
		wr(ptsq_pkg::OFS_SW_START, 16'h0000);
		wait_done(2000);
		chk("conversions", 16'h0003, 16'(cg_q.size()));
		chk("counted", 16'h0003, 16'(n_counted));
		for (int i = 0; i < 3; i++)
			chk("entry", {7'h00, i == 2, 8'(8'h11 * (i + 1))},
				{7'h00, end_q[i], cg_q[i]});
		chk("5 MHz spacing", 16'h0064, 16'(t_q[2] - t_q[1]));
		// Pin triggers on source five: two pretrigger samples, then two counted
		cg_q.delete();
		end_q.delete();
		t_q.delete();
		n_counted = 0;
		src_run <= 1'b1;
		wr(ptsq_pkg::OFS_SI_MODE, ptsq_pkg::MODE_SRC_FIVE);
		wr(ptsq_pkg::OFS_SI_RELOAD, 16'h0003);
		wr(ptsq_pkg::OFS_CNT_LOW, 16'h0002);
		// Entries now step on the far end's first-counter pulses
		wr(ptsq_pkg::OFS_CMD1, 16'h0013);
		fire_pin();
		wait_conv(2);
		fire_pin();
		repeat (3) @(posedge i_core_clk);
		rd(ptsq_pkg::OFS_STATUS, 16'h000B, "status counting");
		wait_done(500);
		repeat (40) @(posedge i_core_clk);
		chk("counted", 16'h0002, 16'(n_counted));
		chk("total", 16'h0004, 16'(cg_q.size()));
		chk("source spacing", 16'h0012, 16'(t_q[1] - t_q[0]));
		// First-counter pulse follows every second conversion
		chk("divided entries", 16'h1122, {cg_q[0], cg_q[1]});
		chk("divided entries", 16'h2233, {cg_q[2], cg_q[3]});
		// Chained count of six: low part 6-1, high part 0+1; scan of 9 ticks
		cg_q.delete();
		end_q.delete();
		t_q.delete();
		n_counted = 0;
		wr(ptsq_pkg::OFS_MEM_FIRST, 16'h0000);
		wr(ptsq_pkg::OFS_SI_MODE, ptsq_pkg::MODE_TB_5M);
		wr(ptsq_pkg::OFS_SI_RELOAD, 16'h0002);
		wr(ptsq_pkg::OFS_SC_MODE, ptsq_pkg::MODE_TB_5M);
		wr(ptsq_pkg::OFS_SC_RELOAD, 16'h0009);
		wr(ptsq_pkg::OFS_CNT_LOW, 16'h0005);
		wr(ptsq_pkg::OFS_CNT_HIGH, 16'h0001);
		wr(ptsq_pkg::OFS_CMD1, 16'h000F);
		rd(ptsq_pkg::OFS_SC_RELOAD, 16'h0009, "scan reload");
		wr(ptsq_pkg::OFS_SW_START, 16'h0000);
		wr(ptsq_pkg::OFS_SW_START, 16'h0000);
		wait_done(1000);
		chk("chained conversions", 16'h0006, 16'(cg_q.size()));
		chk("chained counted", 16'h0006, 16'(n_counted));
		chk("last entry", 16'h0133, {7'h00, end_q[5], cg_q[5]});
		chk("sample spacing", 16'h0064, 16'(t_q[1] - t_q[0]));
		// Sequence end at tick 6 holds off the tick 8 sample until tick 10
		chk("scan hold-off", 16'h00C8, 16'(t_q[3] - t_q[2]));
		rd(ptsq_pkg::OFS_CNT_LOW, 16'h0000, "counter four");
		rd(ptsq_pkg::OFS_CNT_HIGH, 16'h0000, "counter five");
		end_of_test();
	end
	// All three runs need well under ten thousand cycles
	initial begin
		#40000;
		n_mismatch++;
		end_of_test();
	end
endmodule // pretrigger_scan_acquisition_sequencer_bench
`default_nettype wire
